//--- verification/cst_chk_assertions.sv
/* Port checker for cst_top.
 Assumes the bind below. */
`timescale 1ns/100ps
`default_nettype none
`include "cst_cfg.svh"
module cst_chk
(
	input wire logic                    sys_clk_i,
	input wire logic                    arst_n_i,
	input wire logic [`CST_STATE_W-1:0] charge_state_i,
	input wire cst_pkg::cst_cmp_t       pack_sensor_node_i,
	input wire cst_pkg::cst_irq_cfg_t   irq_cfg_i,
	input wire logic                    flag_rd_i,
	input wire logic                    charge_indicator_out_o,
	input wire logic                    charge_indicator_oe_o,
	input wire logic                    restart_cycle_o,
	input wire logic                    temp_suspend_o,
	input wire logic                    range_ok_level_o,
	input wire logic                    range_event_flag_o,
	input wire logic                    irq_n_o
);
default clocking @(posedge sys_clk_i); endclocking
default disable iff (!arst_n_i);
a_ind_sink: assert property (charge_state_i<3 |=> charge_indicator_oe_o) else $error("sink");
a_ind_free: assert property (charge_state_i>2 |=> !charge_indicator_oe_o) else $error("free");
a_temp_susp: assert property (|pack_sensor_node_i |-> ##2 temp_suspend_o) else $error("susp");
a_range_live: assert property (pack_sensor_node_i==0 |-> ##2 range_ok_level_o) else $error("ok");
a_exit_evt: assert property (
	$past(arst_n_i) && $past(~|pack_sensor_node_i) && |pack_sensor_node_i && irq_cfg_i.exit_en
	&& irq_cfg_i.flag_en |=> !irq_n_o) else $error("exit");
a_ret_evt: assert property (
	$past(arst_n_i) && $past(|pack_sensor_node_i) && ~|pack_sensor_node_i && irq_cfg_i.return_en
	&& irq_cfg_i.flag_en |=> !irq_n_o) else $error("ret");
a_rd_data: assert property (flag_rd_i |=> range_event_flag_o != $past(irq_n_o)) else $error("rd");
a_rd_clear: assert property (
	flag_rd_i && $past(arst_n_i) && $stable(~|pack_sensor_node_i) |=> irq_n_o) else $error("clr");
a_restart_req: assert property (
	$past(arst_n_i) && $past(|pack_sensor_node_i) && ~|pack_sensor_node_i |=> restart_cycle_o)
	else $error("restart");
a_restart_idle: assert property (
	$past(arst_n_i) && !($past(|pack_sensor_node_i) && ~|pack_sensor_node_i) |=> !restart_cycle_o)
	else $error("restart idle");
a_ind_drain: assert property (charge_indicator_oe_o |-> !charge_indicator_out_o) else $error("drain");
endmodule
bind cst_top cst_chk cst_chk_i (.*);
`default_nettype wire

//--- verification/cst_host.sv
/* Host model: one flag read pulse per request.
 Assumes one-cycle requests. */
`timescale 1ns/100ps
`default_nettype none
module cst_host
(
	input wire logic sys_clk_i,
	input wire logic go_i,
	output logic     flag_rd_o = 1'h0
);
always @(posedge sys_clk_i) flag_rd_o <= go_i;
endmodule
`default_nettype wire

//--- verification/tb_cst_top.sv
/* Bench of cst_top.
 Assumes cst_host and the checker. */
`timescale 1ns/100ps
`default_nettype none
module tb_cst_top;
logic c = 0, r = 0, go = 0, rd, oe, su, rs, ok, fl, irq, dq;
logic [2:0] st = 3'h0;
cst_pkg::cst_cmp_t tp = 2'h0;
cst_pkg::cst_irq_cfg_t cf = 3'h7;
int bad_count = 0, cmp_count = 0;
cst_top cst_top_i (.sys_clk_i(c), .arst_n_i(r), .charge_state_i(st), .pack_sensor_node_i(tp),
	.irq_cfg_i(cf), .flag_rd_i(rd), .charge_indicator_out_o(dq), .charge_indicator_oe_o(oe),
	.temp_suspend_o(su), .restart_cycle_o(rs), .range_ok_level_o(ok),
	.range_event_flag_o(fl), .irq_n_o(irq));
cst_host cst_host_i (.sys_clk_i(c), .go_i(go), .flag_rd_o(rd));
initial forever #12.5 c = ~c;
task step(int n); repeat (n) @(posedge c); #2; endtask
task cmp(logic [3:0] e, logic [3:0] g);
	cmp_count++;
	if (e !== g)
	begin
		bad_count++;
		$display("BAD %0t %h %h", $time, e, g);
	end
endtask
task t_ind;
	for (int s = 0; s < 7; s++)
	begin
		st = 3'(s);
		step(2);
		cmp({s < 3, 1'h0}, {oe, dq});
	end
endtask
task t_rd(logic e);
	go = 1'h1;
	step(1);
	go = 1'h0;
	step(1);
	cmp(e, fl);
	cmp(1'h1, irq);
endtask
task t_trip(cst_pkg::cst_cmp_t v, logic e);
	tp = v;
	step(1);
	cmp(v == 2'h0, rs);
	step(2);
	cmp({~|v, |v, ~e, 1'h0}, {ok, su, irq, rs});
	t_rd(e);
	t_rd(1'h0);
endtask
// Read strobe and window return land on the same edge: the event must win
task t_race;
	go = 1'h1;
	step(1);
	go = 1'h0;
	tp = 2'h0;
	step(1);
	cmp({1'h0, 1'h0, 1'h1}, {fl, irq, rs});
	t_rd(1'h1);
	t_rd(1'h0);
endtask
task give_verdict;
	$display("bad %0d of %0d", bad_count, cmp_count);
	if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
	else $display("TESTS FAILED");
	$finish;
endtask
initial
begin
	step(10); r = 1; step(1); t_ind;
	t_trip(2'h2, 1); t_trip(2'h0, 1); t_trip(2'h1, 1); t_trip(2'h0, 1);
	cf = 3'h6; t_trip(2'h2, 0); cf = 3'h5; t_trip(2'h0, 0); cf = 3'h3; t_trip(2'h1, 0);
	cf = 3'h7;
	t_race;
	give_verdict;
end
endmodule
`default_nettype wire

//--- verilog/cst_cfg.svh
/*
 Constants of the charger status and battery temperature event block.
 Assumes inclusion by bare name from the design files.
*/
// Notes on behaviour
// - Indicator sinks in precondition, fast-charge, top-off
// - Indicator released in all non-charging states
// - Out-of-window pack temperature suspends charging
// - Exit event when exit enable and flag enable
// - Return event when return enable and flag enable
// - Live range bit high inside window
// - Flag read returns one after an event
// - Each flag read clears the flag unless an event sets it in the same cycle
`ifndef CST_CFG_SVH
`define CST_CFG_SVH
`define CST_STATE_W        3
`define CST_ST_PRECOND     3'h0
`define CST_ST_FAST        3'h1
`define CST_ST_TOPOFF      3'h2
`define CST_ST_EOC         3'h3
`define CST_ST_SUSPEND     3'h4
`define CST_ST_TEMP_FAULT  3'h5
`define CST_ST_TIME_FAULT  3'h6
`define CST_FLAG_RST       1'h0
`define CST_RANGE_RST      1'h1
`define CST_RESTART_CYC    1
`endif

//--- verilog/cst_pkg.sv
/*
 Types of the charger status and battery temperature event block.
 Assumes cst_cfg.svh supplies the widths.
*/
`include "cst_cfg.svh"
package cst_pkg;
	typedef struct packed {
		logic exit_en;
		logic return_en;
		logic flag_en;
	} cst_irq_cfg_t;
	typedef struct packed {
		logic hot_trip;
		logic cold_trip;
	} cst_cmp_t;
endpackage

//--- verilog/cst_range_edge.sv
/*
 Registers the in-window level and reports exit and return edges.
 Assumes comparator inputs synchronous to the clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cst_cfg.svh"
module cst_range_edge
(
	input  wire logic          sys_clk_i,
	input  wire logic          arst_n_i,
	input  wire cst_pkg::cst_cmp_t cmp_i,
	output logic               in_range_o,
	output logic               exit_o,
	output logic               return_o
);
	logic in_d;
	logic in_q;

	assign in_d = ~(cmp_i.hot_trip | cmp_i.cold_trip);

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			in_q <= `CST_RANGE_RST;
		else
			in_q <= in_d;
	end

	assign in_range_o = in_q;
	assign exit_o     = in_q & ~in_d;
	assign return_o   = ~in_q & in_d;
endmodule
`default_nettype wire

//--- verilog/cst_top.sv
/*
 Charge indicator, temperature suspend and temperature event flag.
 Assumes the charge state arrives as an input code and that the flag
 read strobe is one cycle per read access.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cst_cfg.svh"
module cst_top
(
	input  wire logic                      sys_clk_i,
	input  wire logic                      arst_n_i,
	input  wire logic [`CST_STATE_W-1:0]   charge_state_i,
	input  wire cst_pkg::cst_cmp_t         pack_sensor_node_i,
	input  wire cst_pkg::cst_irq_cfg_t     irq_cfg_i,
	input  wire logic                      flag_rd_i,
	output logic                           charge_indicator_out_o,
	output logic                           charge_indicator_oe_o,
	output logic                           temp_suspend_o,
	output logic                           restart_cycle_o,
	output logic                           range_ok_level_o,
	output logic                           range_event_flag_o,
	output logic                           irq_n_o
);
	logic in_range;
	logic exit_ev;
	logic return_ev;
	logic charging;
	logic ev_set;
	logic flag_d;
	logic flag_q;
	logic oe_q;
	logic susp_q;
	logic rst_q;
	logic ok_q;
	logic rdat_q;
	logic irq_n_q;

	cst_range_edge u_edge
	(
		.sys_clk_i  (sys_clk_i),
		.arst_n_i   (arst_n_i),
		.cmp_i      (pack_sensor_node_i),
		.in_range_o (in_range),
		.exit_o     (exit_ev),
		.return_o   (return_ev)
	);

	assign charging = (charge_state_i == `CST_ST_PRECOND) |
	                  (charge_state_i == `CST_ST_FAST) |
	                  (charge_state_i == `CST_ST_TOPOFF);
	// Event beats a read in the same cycle
	assign ev_set = irq_cfg_i.flag_en &
	                ((irq_cfg_i.exit_en & exit_ev) |
	                 (irq_cfg_i.return_en & return_ev));
	assign flag_d = ev_set | (flag_q & ~flag_rd_i);

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			oe_q    <= 1'h0;
			susp_q  <= 1'h0;
			rst_q   <= 1'h0;
			ok_q    <= `CST_RANGE_RST;
			flag_q  <= `CST_FLAG_RST;
			rdat_q  <= 1'h0;
			irq_n_q <= 1'h1;
		end
		else
		begin
			oe_q    <= charging;
			susp_q  <= ~in_range;
			rst_q   <= return_ev;
			ok_q    <= in_range;
			flag_q  <= flag_d;
			rdat_q  <= flag_q;
			irq_n_q <= ~flag_d;
		end
	end

	// Open drain: output low whenever enabled
	assign charge_indicator_out_o = 1'h0;
	assign charge_indicator_oe_o  = oe_q;
	assign temp_suspend_o         = susp_q;
	assign restart_cycle_o        = rst_q;
	assign range_ok_level_o       = ok_q;
	assign range_event_flag_o     = rdat_q;
	assign irq_n_o                = irq_n_q;
endmodule
`default_nettype wire
